// ===== rtl/pdr_forwarder.sv
// delayed read forwarder top with axi4-lite control
`timescale 1ns/1ns
module pdr_forwarder #(
  parameter int DEPTH = 16,             // read data buffer depth
  parameter logic [7:0] PREF_RST = 8'h08
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire pdr_pkg::pdr_treq_t treq,   // initiator read attempt
  input  wire logic             t_take,   // initiator takes a word
  input  wire logic             t_frame_end, // initiator ended burst
  input  wire logic             ord_ok,   // posted writes drained
  output logic [1:0]            t_ans,
  output logic [31:0]           t_data,
  output logic                  t_stop,
  output logic                  m_req,
  output logic [31:0]           m_addr,
  output logic [3:0]            m_cmd,
  output logic [3:0]            m_be,
  output logic                  m_last,
  input  wire logic             m_grant,
  input  wire logic             m_dvalid,
  input  wire logic [31:0]      m_data,
  input  wire logic             m_retry,
  input  wire logic             m_disc,
  input  wire logic             m_err,
  output logic                  primary_system_error_out,
  output logic [1:0]            cfg_type,
  input  wire logic [31:0]      s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [31:0]      s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready
);
  import pdr_pkg::*;
  localparam int AW = $clog2(DEPTH);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    pdr_req_t [PDR_QDEPTH-1:0] q;      // delayed transaction queue
    logic [1:0]  head;                 // entry under execution
    pdr_mst_t    mst;
    logic [23:0] tries;                // retry attempts so far
    logic [7:0]  cnt;                  // words left to prefetch
    logic [31:0] maddr;
    logic        flow;                 // flow-through active
    logic [AW:0] wp;
    logic [AW:0] rp;
    logic [3:0]  wait_c;
    logic [15:0] disc_c;
    logic        bursting;             // initiator data phase live
    logic [1:0]  ans;
    logic [31:0] tdat;
    logic        tstop;
    logic        mreq;
    logic [3:0]  mbe;
    logic        mlast;
    logic        serr;
    logic [1:0]  ctype;
    logic [31:0] ctrl;
    logic [7:0]  pref;
    logic [23:0] rlim;
    logic [15:0] dlim;
    logic [31:0] sts;
    logic [31:0] cfgdec;
    logic        awok;
    logic        wok;
    logic [31:0] awa;
    logic [31:0] wd;
    logic        bv;
    logic        rv;
    logic [31:0] rd;
    logic [1:0]  br;
    logic [1:0]  rr;
  } pdr_st_t;
  pdr_st_t s_q, s_d;
  logic [31:0] buf_q [DEPTH];           // read data buffer
  logic        buf_we;

  // memory reads alias each other
  // command aliasing
  function automatic logic cmd_eq(input logic [3:0] a, input logic [3:0] b);
    logic am;
    logic bm;
    am = (a == PDR_CMD_MRD) || (a == PDR_CMD_MRL) || (a == PDR_CMD_MRM);
    bm = (b == PDR_CMD_MRD) || (b == PDR_CMD_MRL) || (b == PDR_CMD_MRM);
    return (am && bm) || (a == b);
  endfunction : cmd_eq

  // ************************************************************
  // buffer write port
  // ************************************************************
  // one word per clock, no master waits
  always_ff @(posedge aclk)
  begin
    if (buf_we)
    begin
      buf_q[s_q.wp[AW-1:0]] <= m_data;
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    logic        hit;
    logic [1:0]  hidx;
    logic        free;
    logic [1:0]  fidx;
    logic        empty;
    logic        full;
    logic        bnd;
    pdr_req_t    h;
    logic        seterr;
    hit   = 1'b0;
    seterr = 1'b0;
    bnd   = (s_q.maddr[11:2] == PDR_4KB_DW);
    hidx  = 2'd0;
    free  = 1'b0;
    fidx  = 2'd0;
    s_d   = s_q;
    buf_we = 1'b0;
    empty = (s_q.wp == s_q.rp);
    full  = (s_q.wp[AW-1:0] == s_q.rp[AW-1:0]) && (s_q.wp[AW] != s_q.rp[AW]);
    h     = s_q.q[s_q.head];
    s_d.ans   = PDR_ANS_IDLE;
    s_d.tstop = 1'b0;
    // queue search for a match and a free slot
    for (int i = 0; i < PDR_QDEPTH; i++)
    begin
      if (s_q.q[i].valid && s_q.q[i].addr == treq.addr
          && cmd_eq(s_q.q[i].cmd, treq.cmd) && !hit)
      begin
        hit  = 1'b1;
        hidx = i[1:0];
      end
      if (!s_q.q[s_q.head + i[1:0]].valid && !free)
      begin
        free = 1'b1;
        fidx = s_q.head + i[1:0];
      end
    end
    if (treq.start)
    begin
      s_d.ctype  = treq.addr[1:0];
      s_d.cfgdec = {16'h0000, treq.addr[15:11], treq.addr[10:8], treq.addr[7:2], 2'b00};
    end
    // ---- initiator side ----
    if (treq.start && !s_q.bursting)
    begin
      if (hit && s_q.q[hidx].err)
      begin
        // abort to initiator and drop entry
        s_d.ans = PDR_ANS_ABORT;
        s_d.q[hidx].valid = 1'b0;
      end
      // ordering gate; early repeat may stream
      else if (hit && hidx == s_q.head && ord_ok && !empty
               && (h.done || (h.pref && s_q.ctrl[PDR_CTRL_FLOW_EN])))
      begin
        s_d.bursting = 1'b1;
        s_d.flow     = !h.done;
        s_d.ans      = PDR_ANS_DATA;
        s_d.tdat     = buf_q[s_q.rp[AW-1:0]];
        s_d.rp       = s_q.rp + 1'b1;
        s_d.tstop    = !h.pref || (h.done && s_q.rp + 1'b1 == s_q.wp);
        s_d.disc_c   = 16'h0000;
      end
      else
      begin
        // queue and retry; no duplicate store
        s_d.ans = PDR_ANS_RETRY;
        if (!hit && free)
        begin
          // capture address, command, parity, first enables
          s_d.q[fidx] = '{valid: 1'b1, done: 1'b0, err: 1'b0, addr: treq.addr,
                          cmd: treq.cmd, par: treq.par, be: treq.be, pref: treq.pref};
        end
      end
    end
    else if (s_q.bursting)
    begin
      if (t_frame_end || s_q.tstop || !s_q.q[s_q.head].valid)
      begin
        s_d.bursting = 1'b0;
        s_d.flow     = 1'b0;
        s_d.rp       = s_q.wp;
        s_d.q[s_q.head].valid = 1'b0;
        s_d.head     = s_q.head + 2'd1;
        s_d.wait_c   = 4'h0;
        if (s_q.mst != PDR_M_IDLE)
        begin
          s_d.mst  = PDR_M_IDLE;
          s_d.mreq = 1'b0;
          s_d.mlast = 1'b1;
        end
      end
      else if (t_take && !empty)
      begin
        s_d.ans    = PDR_ANS_DATA;
        s_d.tdat   = buf_q[s_q.rp[AW-1:0]];
        s_d.rp     = s_q.rp + 1'b1;
        s_d.wait_c = 4'h0;
        s_d.tstop  = h.done && (s_q.rp + 1'b1 == s_q.wp);
      end
      else if (t_take)
      begin
        // stall up to eight clocks then disconnect
        s_d.ans    = PDR_ANS_IDLE;
        s_d.wait_c = s_q.wait_c + 4'h1;
        s_d.tstop  = (s_q.wait_c + 4'h1 >= PDR_WAIT_MAX);
      end
    end
    // ---- target side master ----
    case (s_q.mst)
      PDR_M_IDLE:
      begin
        s_d.mlast = 1'b0;
        if (h.valid && !h.done && !h.err && empty && !s_q.bursting)
        begin
          s_d.mst   = PDR_M_REQ;
          s_d.mreq  = 1'b1;
          s_d.maddr = h.addr;
          s_d.mbe   = h.be;
          // count from prefetch register; one dword
          s_d.cnt   = h.pref ? s_q.pref : 8'h01;
        end
      end
      PDR_M_REQ:
      begin
        if (m_grant)
        begin
          s_d.mst  = PDR_M_XFER;
          s_d.mreq = 1'b0;
        end
      end
      default:
      begin
        if (m_dvalid && !full)
        begin
          buf_we  = 1'b1;
          s_d.wp  = s_q.wp + 1'b1;
          s_d.cnt = s_q.cnt - 8'h01;
          s_d.maddr = s_q.maddr + 32'h4;
          s_d.tries = 24'h0;
          s_d.mbe = 4'h0;
          // stop at boundary; 4-KB in flow mode; buffer full
          if ((s_q.flow ? bnd : (s_q.cnt == 8'h01)) || m_disc
              || (s_q.wp + 1'b1 == {~s_q.rp[AW], s_q.rp[AW-1:0]}))
          begin
            s_d.mst = PDR_M_IDLE;
            s_d.q[s_q.head].done = 1'b1;
            s_d.mlast = 1'b1;
          end
        end
        else if (m_retry || m_err)
        begin
          s_d.tries = s_q.tries + 24'h1;
          s_d.mst   = PDR_M_IDLE;
          if (m_err || s_q.tries >= s_q.rlim)
          begin
            // give up; error only when enabled
            s_d.q[s_q.head].err = 1'b1;
            s_d.tries = 24'h0;
            seterr    = s_q.ctrl[PDR_CTRL_SERR_EN];
            s_d.head  = s_q.head + 2'd1;
          end
        end
      end
    endcase
    // discard timer on completed head entry
    if (h.valid && h.done && !s_q.bursting)
    begin
      s_d.disc_c = s_q.disc_c + 16'h1;
      if (s_q.disc_c >= s_q.dlim)
      begin
        s_d.q[s_q.head].valid = 1'b0;
        s_d.head   = s_q.head + 2'd1;
        s_d.rp     = s_q.wp;
        s_d.disc_c = 16'h0;
        seterr     = s_q.ctrl[PDR_CTRL_SERR_EN];
      end
    end
    // ---- axi4-lite slave ----
    if (s_axi_awvalid && !s_q.awok)
    begin
      s_d.awok = 1'b1;
      s_d.awa  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_q.wok)
    begin
      s_d.wok = 1'b1;
      s_d.wd  = s_axi_wdata;
    end
    if (s_q.awok && s_q.wok && !s_q.bv)
    begin
      s_d.awok = 1'b0;
      s_d.wok  = 1'b0;
      s_d.bv   = 1'b1;
      s_d.br   = PDR_AXI_OK;
      if (s_q.awa[7:0] == PDR_REG_CTRL)
        s_d.ctrl = s_q.wd;
      else if (s_q.awa[7:0] == PDR_REG_PREF)
        s_d.pref = s_q.wd[7:0];
      else if (s_q.awa[7:0] == PDR_REG_RETRY)
        s_d.rlim = s_q.wd[23:0];
      else if (s_q.awa[7:0] == PDR_REG_DISCARD)
        s_d.dlim = s_q.wd[15:0];
      else if (s_q.awa[7:0] == PDR_REG_STATUS)
        s_d.serr = s_q.serr & ~s_q.wd[0];  // write one to clear
      else
        s_d.br = PDR_AXI_SLVERR;
    end
    if (s_q.bv && s_axi_bready)
      s_d.bv = 1'b0;
    if (s_axi_arvalid && !s_q.rv)
    begin
      s_d.rv = 1'b1;
      s_d.rr = PDR_AXI_OK;
      if (s_axi_araddr[7:0] == PDR_REG_CTRL)
        s_d.rd = s_q.ctrl;
      else if (s_axi_araddr[7:0] == PDR_REG_PREF)
        s_d.rd = {24'h0, s_q.pref};
      else if (s_axi_araddr[7:0] == PDR_REG_RETRY)
        s_d.rd = {8'h0, s_q.rlim};
      else if (s_axi_araddr[7:0] == PDR_REG_DISCARD)
        s_d.rd = {16'h0, s_q.dlim};
      else if (s_axi_araddr[7:0] == PDR_REG_STATUS)
        s_d.rd = {23'h0, s_q.flow, s_q.bursting, s_q.mst, s_q.head, s_q.ctype, s_q.serr};
      else if (s_axi_araddr[7:0] == PDR_REG_CFGDEC)
        s_d.rd = s_q.cfgdec;
      else
      begin
        s_d.rd = 32'h0;
        s_d.rr = PDR_AXI_SLVERR;
      end
    end
    if (s_q.rv && s_axi_rready)
      s_d.rv = 1'b0;
    s_d.serr = s_d.serr | seterr;
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q      <= '0;
      s_q.ans  <= PDR_ANS_IDLE;
      s_q.ctrl <= PDR_CTRL_RST;
      // prefetch count reset is a parameter
      s_q.pref <= PREF_RST;
      s_q.rlim <= PDR_RETRY_RST;
      s_q.dlim <= PDR_DISCARD_RST;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from state flops
  assign t_ans  = s_q.ans;
  assign t_data = s_q.tdat;
  assign t_stop = s_q.tstop;
  assign m_req  = s_q.mreq;
  assign m_addr = s_q.maddr;
  assign m_cmd  = s_q.q[s_q.head].cmd;
  assign m_be   = s_q.mbe;
  assign m_last = s_q.mlast;
  assign primary_system_error_out = s_q.serr;
  assign cfg_type      = s_q.ctype;
  assign s_axi_awready = !s_q.awok;
  assign s_axi_wready  = !s_q.wok;
  assign s_axi_bvalid  = s_q.bv;
  assign s_axi_bresp   = s_q.br;
  assign s_axi_arready = !s_q.rv;
  assign s_axi_rvalid  = s_q.rv;
  assign s_axi_rdata   = s_q.rd;
  assign s_axi_rresp   = s_q.rr;
endmodule : pdr_forwarder

// ===== rtl/pdr_pkg.sv
// constants and carrier types for the delayed read forwarder
// Functional notes
// - non-prefetchable reads fetch one dword, then disconnect
// - prefetchable reads run to aligned boundary
// - boundary from programmable prefetch count outside flow-through
// - disconnect with last word, drop leftovers
// - flow-through reads stop at 4-KB boundary
// - every read queued and answered with retry
// - capture address, command, parity, first byte enables
// - replay exact captured address and command
// - first byte enables, then all enabled later
// - reissue on retry, stop after data moved
// - retry limit: target abort, drop, gated error
// - accept one word per clock, no waits
// - memory read commands alias when matching
// - release data only after ordering cleared
// - early repeat enters flow-through mode
// - empty buffer: eight wait clocks, then disconnect
// - initiator end forwards frame end, discards data
// - discard timer drops unclaimed completion
// - four queue entries, duplicates not stored
// - config type from low address bits
// - register and function number field decode
package pdr_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] PDR_REG_CTRL    = 8'h00; // control word
  localparam logic [7:0] PDR_REG_PREF    = 8'h04; // prefetch count
  localparam logic [7:0] PDR_REG_RETRY   = 8'h08; // retry limit
  localparam logic [7:0] PDR_REG_DISCARD = 8'h0c; // discard count
  localparam logic [7:0] PDR_REG_STATUS  = 8'h10; // status
  localparam logic [7:0] PDR_REG_CFGDEC  = 8'h14; // config decode
  localparam int PDR_CTRL_SERR_EN = 8;   // command register error enable bit
  localparam int PDR_CTRL_FLOW_EN = 0;   // flow-through enable bit
  localparam logic [31:0] PDR_CTRL_RST = 32'h0000_0001;
  localparam logic [7:0]  PDR_PREF_RST = 8'h08;
  localparam logic [23:0] PDR_RETRY_RST = 24'hff_ffff; // 2^24 attempts
  localparam logic [15:0] PDR_DISCARD_RST = 16'h8000;
  localparam logic [3:0]  PDR_WAIT_MAX = 4'h8;         // eight clocks
  localparam logic [9:0]  PDR_4KB_DW = 10'h3ff;        // last dword of 4 KB
  localparam int PDR_QDEPTH = 4;
  localparam logic [3:0] PDR_CMD_IORD = 4'h2;
  localparam logic [3:0] PDR_CMD_MRD  = 4'h6;
  localparam logic [3:0] PDR_CMD_CFGRD = 4'ha;
  localparam logic [3:0] PDR_CMD_MRM  = 4'hc;
  localparam logic [3:0] PDR_CMD_MRL  = 4'he;
  localparam logic [1:0] PDR_AXI_OK = 2'b00;
  localparam logic [1:0] PDR_AXI_SLVERR = 2'b10;
  // target answers to the initiator
  typedef enum logic [1:0] {
    PDR_ANS_RETRY = 2'b00,
    PDR_ANS_DATA  = 2'b01,
    PDR_ANS_ABORT = 2'b10,
    PDR_ANS_IDLE  = 2'b11
  } pdr_ans_t;
  // master side states
  typedef enum logic [1:0] {
    PDR_M_IDLE = 2'b00,
    PDR_M_REQ  = 2'b01,
    PDR_M_XFER = 2'b10
  } pdr_mst_t;
  // one captured delayed request
  typedef struct packed {
    logic        valid;
    logic        done;
    logic        err;
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic        par;
    logic [3:0]  be;
    logic        pref;
  } pdr_req_t;
  // initiator-side request strobe
  typedef struct packed {
    logic        start;
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic        par;
    logic [3:0]  be;
    logic        pref;
  } pdr_treq_t;
endpackage : pdr_pkg

// ===== tb/pdr_forwarder_bench.sv
// self-checking bench for the delayed read forwarder
`timescale 1ns/1ns
module pdr_forwarder_bench;
  import pdr_pkg::*;
  logic        aclk = 0, aresetn = 0, t_take = 1, t_frame_end = 0, ord_ok = 1, refuse = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  pdr_treq_t   treq = '0;
  logic        t_stop, m_req, m_last, m_grant, m_dvalid, m_retry, m_disc, m_err, stp;
  logic        primary_system_error_out, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  t_ans, cfg_type, s_axi_bresp, s_axi_rresp, r, ans;
  logic [3:0]  m_cmd, m_be, seen_cmd, seen_be;
  logic [31:0] t_data, m_addr, m_data, s_axi_rdata, seen_addr, d, dat, a;
  logic [7:0]  ra [4] = '{PDR_REG_CTRL, PDR_REG_PREF, PDR_REG_RETRY, PDR_REG_DISCARD};
  logic [31:0] rv [4] = '{PDR_CTRL_RST, {24'h0, PDR_PREF_RST}, {8'h0, PDR_RETRY_RST},
                          {16'h0, PDR_DISCARD_RST}};
  int          fails = 0, tests_run = 0;
  always #10 aclk = ~aclk;
  pdr_forwarder i_pdr_forwarder (.aclk, .aresetn, .treq, .t_take, .t_frame_end, .ord_ok,
    .t_ans, .t_data, .t_stop, .m_req, .m_addr, .m_cmd, .m_be, .m_last, .m_grant, .m_dvalid,
    .m_data, .m_retry, .m_disc, .m_err, .primary_system_error_out, .cfg_type, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  pdr_target_model i_pdr_target_model (.aclk, .aresetn, .m_req, .m_addr, .m_cmd, .m_be,
    .m_last, .refuse, .m_grant, .m_dvalid, .m_data, .m_retry, .m_disc, .m_err, .seen_addr,
    .seen_cmd, .seen_be);
  // ************************************************************
  // checks and verdict
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk_ans(input string nm, input pdr_ans_t e);
    chk(nm, {30'h0, e}, {30'h0, ans});
  endtask : chk_ans
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test
  // ************************************************************
  // register bus master: valid held until its own ready
  // ************************************************************
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] wd);
    @(posedge aclk);
    s_axi_awaddr  <= {24'h0, ad};
    s_axi_wdata   <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, PDR_AXI_OK}, {30'h0, s_axi_bresp});
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] ad);
    @(posedge aclk);
    s_axi_araddr  <= {24'h0, ad};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // ************************************************************
  // initiator attempts; the answer stands one cycle
  // ************************************************************
  task automatic attempt(input logic [31:0] ad, input logic [3:0] c, input logic [3:0] b,
                         input logic p);
    @(posedge aclk);
    treq <= '{start: 1'b1, addr: ad, cmd: c, par: ^{ad, c}, be: b, pref: p};
    @(posedge aclk);
    treq.start <= 1'b0;
    #1;
    ans = t_ans;
    dat = t_data;
    stp = t_stop;
  endtask : attempt
  // repeat the read while retried
  task automatic rep_read(input logic [31:0] ad, input logic [3:0] c, input logic p);
    for (int n = 0; n < 100 && (n == 0 || ans == PDR_ANS_RETRY); n++)
      attempt(ad, c, 4'h3, p);
  endtask : rep_read
  task automatic wait_last;
    for (int n = 0; n < 400 && !m_last; n++)
      @(posedge aclk);
    chk("m_last", 32'h1, {31'h0, m_last});
  endtask : wait_last
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      axi_rd(ra[i]);
      chk("reset value", rv[i], d);
    end
    axi_rd(8'h40);
    chk("unmapped resp", {30'h0, PDR_AXI_SLVERR}, {30'h0, r});
    // error output and flow-through enabled
    axi_wr(PDR_REG_CTRL, 32'h0000_0101);
    a = 32'h1000_0010;
    attempt(a, PDR_CMD_IORD, 4'h3, 1'b0);
    chk_ans("first answer", PDR_ANS_RETRY);
    wait_last;
    chk("replay addr", a, seen_addr);
    chk("replay cmd", {28'h0, PDR_CMD_IORD}, {28'h0, seen_cmd});
    chk("replay be", 32'h3, {28'h0, seen_be});
    ord_ok <= 1'b0;
    attempt(a, PDR_CMD_IORD, 4'h3, 1'b0);
    chk_ans("held answer", PDR_ANS_RETRY);
    @(posedge aclk);
    ord_ok <= 1'b1;
    rep_read(a, PDR_CMD_IORD, 1'b0);
    chk_ans("single answer", PDR_ANS_DATA);
    chk("single word", a ^ 32'h5a5a_0000, dat);
    chk("disconnect", 32'h1, {31'h0, stp});
    // configuration reads of both address types
    for (int i = 0; i < 2; i++)
    begin
      a = 32'h0000_0a04 | i;
      attempt(a, PDR_CMD_CFGRD, 4'h3, 1'b0);
      chk("cfg type", i, {30'h0, cfg_type});
      wait_last;
      rep_read(a, PDR_CMD_CFGRD, 1'b0);
      chk_ans("cfg answer", PDR_ANS_DATA);
      axi_rd(PDR_REG_CFGDEC);
      chk("cfg fields", a & 32'hfffc, d);
    end
    // prefetchable read claimed with an aliased command
    a = 32'h2000_0000;
    attempt(a, PDR_CMD_MRD, 4'h3, 1'b1);
    wait_last;
    chk("pref be", 32'h3, {28'h0, seen_be});
    rep_read(a, PDR_CMD_MRM, 1'b1);
    chk_ans("alias answer", PDR_ANS_DATA);
    chk("alias word", a ^ 32'h5a5a_0000, dat);
    @(posedge aclk);
    t_frame_end <= 1'b1;
    t_take      <= 1'b0;
    @(posedge aclk);
    t_frame_end <= 1'b0;
    t_take      <= 1'b1;
    // retry limit: target abort, error output
    axi_wr(PDR_REG_RETRY, 32'h3);
    refuse <= 1'b1;
    rep_read(32'h3000_0040, PDR_CMD_MRD, 1'b0);
    chk_ans("limit answer", PDR_ANS_ABORT);
    chk("error out", 32'h1, {31'h0, primary_system_error_out});
    refuse <= 1'b0;
    axi_wr(PDR_REG_STATUS, 32'h1);
    repeat (2) @(posedge aclk);
    chk("error clear", 32'h0, {31'h0, primary_system_error_out});
    // unclaimed completion dropped, fetched again
    axi_wr(PDR_REG_DISCARD, 32'h10);
    a = 32'h1000_0080;
    attempt(a, PDR_CMD_IORD, 4'h3, 1'b0);
    wait_last;
    repeat (60) @(posedge aclk);
    attempt(a, PDR_CMD_IORD, 4'h3, 1'b0);
    chk_ans("after discard", PDR_ANS_RETRY);
    wait_last;
    rep_read(a, PDR_CMD_IORD, 1'b0);
    chk_ans("refetch answer", PDR_ANS_DATA);
    rep_read(32'h2000_0ff0, PDR_CMD_MRL, 1'b1);
    repeat (8) @(posedge aclk);
    chk("flow bound", 32'h2000_1000, m_addr);
    end_of_test();
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge aclk);
    fails++;
    end_of_test();
  end
endmodule : pdr_forwarder_bench

// ===== tb/pdr_forwarder_sva.sv
// port assertions for the delayed read forwarder
`timescale 1ns/1ns
module pdr_forwarder_sva
  import pdr_pkg::*;
(
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire pdr_pkg::pdr_treq_t treq,
  input wire logic               ord_ok,
  input wire logic [1:0]         t_ans,
  input wire logic               t_stop,
  input wire logic               m_req,
  input wire logic [31:0]        m_addr,
  input wire logic [3:0]         m_cmd,
  input wire logic               m_grant,
  input wire logic               primary_system_error_out,
  input wire logic [1:0]         cfg_type,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ************************************************************
  // initiator side
  // ************************************************************
  start_ans_a: assert property (treq.start |=> t_ans != PDR_ANS_IDLE)
    else $error("attempt left unanswered");
  cfg_type_a: assert property (treq.start |=> cfg_type == $past(treq.addr[1:0]))
    else $error("config type not from low address bits");
  data_order_a: assert property (t_ans == PDR_ANS_DATA |-> $past(ord_ok))
    else $error("data released before ordering cleared");
  stop_word_a: assert property (t_stop |-> t_ans inside {PDR_ANS_DATA, PDR_ANS_IDLE})
    else $error("disconnect with retry or abort");
  // ************************************************************
  // master side and error output
  // ************************************************************
  grant_hold_a: assert property (m_req && !m_grant |=> m_req && $stable(m_addr) && $stable(m_cmd))
    else $error("request dropped or changed before grant");
  err_sticky_a: assert property (primary_system_error_out && !s_axi_wvalid
    && !$past(s_axi_wvalid) && !s_axi_bvalid |=> primary_system_error_out)
    else $error("error output fell without a clear");
  // ************************************************************
  // register bus answers
  // ************************************************************
  aw_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  ar_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
endmodule : pdr_forwarder_sva
bind pdr_forwarder pdr_forwarder_sva i_pdr_forwarder_sva (.aclk, .aresetn, .treq, .ord_ok,
  .t_ans, .t_stop, .m_req, .m_addr, .m_cmd, .m_grant, .primary_system_error_out, .cfg_type,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// ===== tb/pdr_target_model.sv
// target-bus responder facing the forwarder's master side
`timescale 1ns/1ns
module pdr_target_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        m_req,
  input  wire logic [31:0] m_addr,
  input  wire logic [3:0]  m_cmd,
  input  wire logic [3:0]  m_be,
  input  wire logic        m_last,
  input  wire logic        refuse,    // answer every attempt with retry
  output logic             m_grant,
  output logic             m_dvalid,
  output logic [31:0]      m_data,
  output logic             m_retry,
  output logic             m_disc,
  output logic             m_err,
  output logic [31:0]      seen_addr, // address of the last granted request
  output logic [3:0]       seen_cmd,
  output logic [3:0]       seen_be
);
  logic        active; // burst running
  logic        rpend;  // retry owed next cycle
  logic [31:0] word;   // next word handed over
  assign m_disc = 1'b0;
  assign m_err  = 1'b0;
  // ************************************************************
  // grant, retry and one word per clock while the burst runs
  // ************************************************************
  always_ff @(posedge aclk)
  begin
    m_grant <= 1'b0;
    m_retry <= rpend;
    rpend   <= 1'b0;
    if (!aresetn)
    begin
      active   <= 1'b0;
      m_dvalid <= 1'b0;
      m_data   <= 32'h0;
    end
    else if (m_req && !m_grant && !active && !rpend)
    begin
      m_grant   <= 1'b1;
      seen_addr <= m_addr;
      seen_cmd  <= m_cmd;
      seen_be   <= m_be;
      word      <= m_addr ^ 32'h5a5a_0000;
      active    <= !refuse;
      rpend     <= refuse;
    end
    else if (active && !m_last)
    begin
      m_dvalid <= 1'b1;
      m_data   <= word;
      word     <= word + 32'h1;
    end
    else
    begin
      // released bus shows no stale word
      active   <= 1'b0;
      m_dvalid <= 1'b0;
      m_data   <= ~m_data;
    end
  end
endmodule : pdr_target_model
